// ==== rtl/csc_pkg.sv ====
// Package of constants and types for the clock source mode control block.
// Notes on behaviour
// [R1] Software changes the reference divider in the same write as selects.
// [R2] Reference status follows its select after some divided reference cycles.
// [R3] Output moves to a new clock only after some cycles of it.
// [R4] An unavailable new clock leaves the previous one selected.
// [R5] Bus divider changes act on the output at once.
// [R6] Low-power bit clear keeps the loop on and locking in bypass.
// [R7] Internal reference output enable drives the internal reference out.
// [R8] Larger trim lengthens the internal reference period.
// [R9] Trim reaches the main output only in internal reference modes.
// [R10] Coarse and fine trim survive every reset; the code reloads both on pwr_up_i.
// [R11] Internal reference runs in stop when both its enables are set.
// [R12] Software may load the stored trim, fine trim excluded; the code also lets software write fine trim through bit 0 at ADR_STAT.
// [R13] External reference stays between 31.25 kHz and 5 MHz.
// [R14] External reference output enable drives the external reference out.
// [R15] With reference select set the loop ignores the external reference.
// [R16] External reference runs in stop when both its enables are set.
// [R17] The divided loop reference leaves as the fixed-frequency clock.
// [R18] Valid flag is always high in both loop-engaged modes.
// [R19] In bypass, valid needs reference divider at least bus divider plus 2.
// [R20] The running loop locks to 1024 times the divided reference; the code instead toggles the loop output every ref_clk_i cycle once locked.
// [R21] Output select 00 loop, 01 internal, 10 external, 11 reserved.
// [R22] Bypass, low-power set, no debug: loop and debug clock off.
// [R23] Status bits change through synchronised, glitch-free switching.
package csc_pkg;
   localparam logic [2:0] ADR_CTRL1 = 3'h0;
   localparam logic [2:0] ADR_CTRL2 = 3'h1;
   localparam logic [2:0] ADR_TRIM = 3'h2;
   localparam logic [2:0] ADR_STAT = 3'h3;
   localparam logic [7:0] CTRL1_RST = 8'h04;
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [7:0] CTRL2_MASK = 8'hcd;
   localparam logic [7:0] TRIM_PWRUP = 8'h80;
   localparam logic [9:0] IRC_BASE = 10'h010;
   localparam logic [1:0] SYNC_LAST = 2'h2;
   localparam logic [2:0] LOCK_CNT = 3'h4;
   localparam int LOOP_MULT = 1024;
   localparam logic [1:0] SEL_LOOP = 2'h0;
   localparam logic [1:0] SEL_INT = 2'h1;
   localparam logic [1:0] SEL_EXT = 2'h2;
   localparam logic [1:0] SEL_RSV = 2'h3;
   localparam logic [3:0] FFE_MARGIN = 4'h2;
   typedef struct packed {
      logic [1:0] clk_sel;
      logic [2:0] reference_divider;
      logic ref_sel;
      logic internal_ref_output_enable;
      logic internal_ref_stop_enable;
   } csc_ctrl1_s;
   typedef struct packed {
      logic [1:0] bus_divider;
      logic [1:0] rsv_hi;
      logic lp;
      logic external_ref_output_enable;
      logic rsv_lo;
      logic external_ref_stop_enable;
   } csc_ctrl2_s;
   typedef enum logic [1:0] {
      CS_HOLD = 2'b01,
      CS_SYNC = 2'b10
   } csc_sw_e;
endpackage : csc_pkg

// ==== rtl/csc_top.sv ====
// Clock source mode control block, modelled in the reference clock domain.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module csc_top (
   // Clock, reset, enable
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic pwr_up_i,
   input wire logic ce_i,
   // Register port
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rd_data_o,
   // Chip state and external reference pin
   input wire logic stop_i,
   input wire logic debug_mode_i,
   input wire logic ext_ref_clk_i,
   // Clock outputs
   output logic main_output_clock_o,
   output logic internal_ref_clock_out_o,
   output logic external_ref_clock_out_o,
   output logic fixed_frequency_clock_o,
   output logic fixed_frequency_valid_o,
   output logic debug_comm_clock_o,
   output logic loop_locked_o
);
   csc_pkg::csc_ctrl1_s c1_r, c1_nxt;
   csc_pkg::csc_ctrl2_s c2_r, c2_nxt;
   logic [7:0] trim_r, trim_nxt;
   logic fine_trim_r, fine_trim_nxt;
   logic [7:0] rd_r, rd_nxt;
   logic ext1_r, ext2_r, ext3_r;
   logic [9:0] irc_cnt_r, irc_cnt_nxt, irc_half;
   logic irc_r, irc_nxt, irc_run, irc_rise, ext_rise;
   logic [7:0] dcnt_r, dcnt_nxt;
   logic raw_rise, dref_lvl, dref_rise, ff_r;
   logic ref_st_r, ref_st_nxt, sw_done;
   logic [1:0] rsw_r, rsw_nxt;
   logic [2:0] lock_r, lock_nxt;
   logic loop_en, locked, loop_on, loop_ph_r, loop_ph_nxt, lk_r, lk_nxt;
   csc_pkg::csc_sw_e st_r, st_nxt;
   logic [1:0] clk_st_r, clk_st_nxt, tgt_r, tgt_nxt;
   logic [1:0] osw_r, osw_nxt;
   logic tgt_rise, sel_lvl, sel_prev_r, sel_rise;
   logic [2:0] bcnt_r, bcnt_nxt;
   logic main_r, main_nxt, ffe_r, ffe_nxt;
   logic irco_r, irco_nxt, erco_r, erco_nxt, dbg_r;

   // Trim holds through sys_rst_i; only power-up loads a start value.
   always_comb begin
      trim_nxt = trim_r;
      fine_trim_nxt = fine_trim_r;
      if (ce_i && pwr_up_i) begin
         trim_nxt = csc_pkg::TRIM_PWRUP;
         fine_trim_nxt = 1'b0;
      end else if (ce_i && wr_i && addr_i == csc_pkg::ADR_TRIM) begin
         trim_nxt = wr_data_i;
      end else if (ce_i && wr_i && addr_i == csc_pkg::ADR_STAT) begin
         fine_trim_nxt = wr_data_i[0];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      trim_r <= trim_nxt; // [R10]
      fine_trim_r <= fine_trim_nxt; // [R10]
   end

   // Control registers and read port.
   always_comb begin
      c1_nxt = c1_r;
      c2_nxt = c2_r;
      rd_nxt = 8'h00;
      if (wr_i && addr_i == csc_pkg::ADR_CTRL1) begin
         c1_nxt = csc_pkg::csc_ctrl1_s'(wr_data_i);
      end
      if (wr_i && addr_i == csc_pkg::ADR_CTRL2) begin
         c2_nxt = csc_pkg::csc_ctrl2_s'(wr_data_i & csc_pkg::CTRL2_MASK);
      end
      if (rd_i) begin
         unique case (addr_i)
            csc_pkg::ADR_CTRL1: rd_nxt = c1_r;
            csc_pkg::ADR_CTRL2: rd_nxt = c2_r;
            csc_pkg::ADR_TRIM: rd_nxt = trim_r;
            csc_pkg::ADR_STAT: begin
               rd_nxt = {3'h0, ref_st_r, clk_st_r, locked, fine_trim_r};
            end
            default: rd_nxt = 8'h00;
         endcase
      end
   end

   // Pin synchroniser; only ext2_r reads ext1_r.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ext1_r <= 1'b0;
         ext2_r <= 1'b0;
         ext3_r <= 1'b0;
      end else if (ce_i) begin
         ext1_r <= ext_ref_clk_i;
         ext2_r <= ext1_r;
         ext3_r <= ext2_r;
      end
   end

   assign ext_rise = ext2_r && !ext3_r;

   // Internal reference: half period grows with the trim value.
   assign irc_half = csc_pkg::IRC_BASE + {2'b00, trim_r}
      + {9'h000, fine_trim_r}; // [R8]
   assign irc_run = !stop_i || (c1_r.internal_ref_output_enable && c1_r.internal_ref_stop_enable); // [R11]
   assign irc_rise = irc_run && irc_cnt_r >= irc_half && !irc_r;

   // Loop reference and its divider.
   assign raw_rise = c1_r.ref_sel ? irc_rise : ext_rise; // [R15]
   assign dref_lvl = (c1_r.reference_divider == 3'h0)
      ? (c1_r.ref_sel ? irc_r : ext3_r)
      : dcnt_r[3'(c1_r.reference_divider - 3'h1)];
   assign dref_rise = dref_lvl && !ff_r;
   assign sw_done = (c1_r.ref_sel != ref_st_r) && dref_rise
      && rsw_r == csc_pkg::SYNC_LAST;
   // The loop stops only in low-power bypass without debug.
   assign loop_en = !(clk_st_r != csc_pkg::SEL_LOOP && c2_r.lp
      && !debug_mode_i); // [R6] [R22]
   assign locked = lock_r == csc_pkg::LOCK_CNT;
   assign loop_on = loop_en && locked && !stop_i; // [R20]

   always_comb begin
      irc_cnt_nxt = irc_cnt_r;
      irc_nxt = irc_r;
      if (irc_run) begin
         if (irc_cnt_r >= irc_half) begin
            irc_cnt_nxt = 10'h000;
            irc_nxt = !irc_r;
         end else begin
            irc_cnt_nxt = irc_cnt_r + 10'h001;
         end
      end
      dcnt_nxt = dcnt_r + {7'h00, raw_rise};
      ref_st_nxt = ref_st_r;
      rsw_nxt = 2'h0;
      if (c1_r.ref_sel != ref_st_r && !stop_i) begin
         rsw_nxt = rsw_r + {1'b0, dref_rise};
         if (sw_done) begin
            ref_st_nxt = c1_r.ref_sel; // [R2] [R23]
            rsw_nxt = 2'h0;
         end
      end
      lock_nxt = lock_r;
      if (!loop_en || sw_done) begin
         lock_nxt = 3'h0; // [R2]
      end else if (dref_rise && !locked) begin
         lock_nxt = lock_r + 3'h1;
      end
      lk_nxt = lock_nxt == csc_pkg::LOCK_CNT;
      // Loop output is modelled as the fastest toggle this clock allows.
      loop_ph_nxt = loop_on ? !loop_ph_r : 1'b0;
   end

   // Output clock switch: count edges of the target before moving.
   always_comb begin
      unique case (tgt_r)
         csc_pkg::SEL_LOOP: tgt_rise = loop_on && !loop_ph_r;
         csc_pkg::SEL_INT: tgt_rise = irc_rise;
         csc_pkg::SEL_EXT: tgt_rise = ext_rise;
         default: tgt_rise = 1'b0;
      endcase
      st_nxt = st_r;
      tgt_nxt = tgt_r;
      osw_nxt = osw_r;
      clk_st_nxt = clk_st_r;
      unique case (st_r)
         csc_pkg::CS_HOLD: begin
            if (c1_r.clk_sel != clk_st_r
               && c1_r.clk_sel != csc_pkg::SEL_RSV) begin // [R21]
               st_nxt = csc_pkg::CS_SYNC;
               tgt_nxt = c1_r.clk_sel;
               osw_nxt = 2'h0;
            end
         end
         csc_pkg::CS_SYNC: begin
            if (c1_r.clk_sel != tgt_r) begin
               st_nxt = csc_pkg::CS_HOLD;
            end else if (tgt_rise) begin
               // With no edges from the target, the old clock stays.
               osw_nxt = osw_r + 2'h1; // [R4]
               if (osw_r == csc_pkg::SYNC_LAST) begin
                  clk_st_nxt = tgt_r; // [R3] [R23]
                  st_nxt = csc_pkg::CS_HOLD;
               end
            end
         end
      endcase
   end

   // Main output, bus divider and fixed-frequency flag.
   always_comb begin
      unique case (clk_st_r)
         csc_pkg::SEL_LOOP: sel_lvl = loop_ph_r;
         csc_pkg::SEL_INT: sel_lvl = irc_r; // [R9]
         csc_pkg::SEL_EXT: sel_lvl = ext3_r;
         default: sel_lvl = 1'b0;
      endcase
      sel_rise = sel_lvl && !sel_prev_r;
      bcnt_nxt = bcnt_r + {2'b00, sel_rise};
      main_nxt = main_r;
      if (!stop_i) begin
         main_nxt = (c2_r.bus_divider == 2'b00) ? sel_lvl
            : bcnt_r[2'(c2_r.bus_divider - 2'b01)]; // [R5]
      end
      ffe_nxt = (clk_st_r == csc_pkg::SEL_LOOP)
         || ({1'b0, c1_r.reference_divider}
         >= {2'b00, c2_r.bus_divider} + csc_pkg::FFE_MARGIN); // [R18] [R19]
      irco_nxt = c1_r.internal_ref_output_enable && irc_r; // [R7]
      erco_nxt = c2_r.external_ref_output_enable && ext3_r; // [R14]
      if (stop_i && !(c2_r.external_ref_output_enable && c2_r.external_ref_stop_enable)) begin
         erco_nxt = erco_r; // [R16]
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         c1_r <= csc_pkg::csc_ctrl1_s'(csc_pkg::CTRL1_RST);
         c2_r <= csc_pkg::csc_ctrl2_s'(csc_pkg::CTRL2_RST);
         rd_r <= 8'h00;
         irc_cnt_r <= 10'h000;
         irc_r <= 1'b0;
         dcnt_r <= 8'h00;
         ff_r <= 1'b0;
         ref_st_r <= 1'b1;
         rsw_r <= 2'h0;
         lock_r <= 3'h0;
         lk_r <= 1'b0;
         loop_ph_r <= 1'b0;
         st_r <= csc_pkg::CS_HOLD;
         tgt_r <= csc_pkg::SEL_LOOP;
         osw_r <= 2'h0;
         clk_st_r <= csc_pkg::SEL_LOOP;
         sel_prev_r <= 1'b0;
         bcnt_r <= 3'h0;
         main_r <= 1'b0;
         ffe_r <= 1'b0;
         irco_r <= 1'b0;
         erco_r <= 1'b0;
         dbg_r <= 1'b0;
      end else if (ce_i) begin
         c1_r <= c1_nxt;
         c2_r <= c2_nxt;
         rd_r <= rd_nxt;
         irc_cnt_r <= irc_cnt_nxt;
         irc_r <= irc_nxt;
         dcnt_r <= dcnt_nxt;
         ff_r <= dref_lvl; // [R17]
         ref_st_r <= ref_st_nxt;
         rsw_r <= rsw_nxt;
         lock_r <= lock_nxt;
         lk_r <= lk_nxt;
         loop_ph_r <= loop_ph_nxt;
         st_r <= st_nxt;
         tgt_r <= tgt_nxt;
         osw_r <= osw_nxt;
         clk_st_r <= clk_st_nxt;
         sel_prev_r <= sel_lvl;
         bcnt_r <= bcnt_nxt;
         main_r <= main_nxt;
         ffe_r <= ffe_nxt;
         irco_r <= irco_nxt;
         erco_r <= erco_nxt;
         dbg_r <= loop_en; // [R22]
      end
   end

   assign rd_data_o = rd_r;
   assign main_output_clock_o = main_r;
   assign internal_ref_clock_out_o = irco_r;
   assign external_ref_clock_out_o = erco_r;
   assign fixed_frequency_clock_o = ff_r;
   assign fixed_frequency_valid_o = ffe_r;
   assign debug_comm_clock_o = dbg_r;
   assign loop_locked_o = lk_r;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i || pwr_up_i || !ce_i);

   sequence s_ref_last;
      dref_rise && rsw_r == csc_pkg::SYNC_LAST;
   endsequence
   sequence s_out_last;
      st_r == csc_pkg::CS_SYNC && tgt_rise
         && osw_r == csc_pkg::SYNC_LAST && c1_r.clk_sel == tgt_r;
   endsequence

   property p_ref_status;
      $changed(ref_st_r) |-> $past(c1_r.ref_sel != ref_st_r) && $past(dref_rise)
         && $past(rsw_r) == csc_pkg::SYNC_LAST;
   endproperty
   a_ref_status: assert property (p_ref_status) // [R2]
      else $error("reference status moved early");
   property p_ref_restart;
      (c1_r.ref_sel != ref_st_r && !stop_i) ##0 s_ref_last
         |=> lock_r == 3'h0;
   endproperty
   a_ref_restart: assert property (p_ref_restart) // [R2]
      else $error("loop did not restart locking");
   property p_out_status;
      $changed(clk_st_r) |-> $past(st_r == csc_pkg::CS_SYNC && tgt_rise
         && osw_r == csc_pkg::SYNC_LAST);
   endproperty
   a_out_status: assert property (p_out_status) // [R3]
      else $error("output status moved early");
   property p_out_done;
      s_out_last |=> clk_st_r == $past(tgt_r);
   endproperty
   a_out_done: assert property (p_out_done) // [R3]
      else $error("output switch not taken");
   property p_no_clock;
      (st_r == csc_pkg::CS_SYNC && !tgt_rise) |=> $stable(clk_st_r);
   endproperty
   a_no_clock: assert property (p_no_clock) // [R4]
      else $error("switched to absent clock");
   property p_bus_divider;
      (c2_r.bus_divider == 2'b00 && !stop_i) |=> main_r == $past(sel_lvl);
   endproperty
   a_bus_divider: assert property (p_bus_divider) // [R5]
      else $error("bus divider one not direct");
   property p_lp_clear;
      !c2_r.lp |=> debug_comm_clock_o;
   endproperty
   a_lp_clear: assert property (p_lp_clear) // [R6]
      else $error("loop off with low power clear");
   property p_lp_off;
      (clk_st_r != csc_pkg::SEL_LOOP && c2_r.lp && !debug_mode_i)
         |-> !loop_on ##1 !debug_comm_clock_o;
   endproperty
   a_lp_off: assert property (p_lp_off) // [R22]
      else $error("loop on in low-power bypass");
   property p_irc_out;
      !c1_r.internal_ref_output_enable |=> !internal_ref_clock_out_o;
   endproperty
   a_irc_out: assert property (p_irc_out) // [R7]
      else $error("internal reference out not gated");
   property p_irc_stop;
      (stop_i && !(c1_r.internal_ref_output_enable && c1_r.internal_ref_stop_enable)) |=> $stable(irc_r);
   endproperty
   a_irc_stop: assert property (p_irc_stop) // [R11]
      else $error("internal reference ran in stop");
   property p_trim;
      (irc_run && irc_cnt_r < irc_half) |=> $stable(irc_r);
   endproperty
   a_trim: assert property (p_trim) // [R8]
      else $error("internal reference toggled early");
   property p_ffe_eng;
      clk_st_r == csc_pkg::SEL_LOOP |=> fixed_frequency_valid_o;
   endproperty
   a_ffe_eng: assert property (p_ffe_eng) // [R18]
      else $error("valid low in engaged mode");
   property p_ffe_byp;
      (clk_st_r != csc_pkg::SEL_LOOP && {1'b0, c1_r.reference_divider}
         < {2'b00, c2_r.bus_divider} + csc_pkg::FFE_MARGIN)
         |=> !fixed_frequency_valid_o;
   endproperty
   a_ffe_byp: assert property (p_ffe_byp) // [R19]
      else $error("valid high below divider limit");
   property p_int_ref;
      c1_r.ref_sel |-> raw_rise == irc_rise;
   endproperty
   a_int_ref: assert property (p_int_ref) // [R15]
      else $error("loop used external reference");
endmodule : csc_top
`default_nettype wire

// ==== tb/csc_ext_osc.sv ====
// Behavioural external reference oscillator driving the clock pin.
`timescale 1ns/10ps
`default_nettype none
module csc_ext_osc (
   // Control
   input wire logic run_i,
   input wire logic [15:0] half_ns_i,
   // Clock pin
   output logic clk_o
);
   int h;
   initial begin
      clk_o = 1'b0;
      forever begin
         // Half period clamped to 31.25 kHz up to 5 MHz.
         h = (half_ns_i < 16'd100) ? 100 : int'(half_ns_i);
         if (h > 16000) begin
            h = 16000;
         end
         #(h);
         // A stopped source holds its pin still, so the block sees no edges.
         if (run_i) begin
            clk_o = ~clk_o;
         end
      end
   end
endmodule : csc_ext_osc
`default_nettype wire

// ==== tb/csc_top_bench.sv ====
// Self-checking bench for the clock source mode control block.
`timescale 1ns/10ps
`default_nettype none
module csc_top_bench;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i, pwr_up_i, ce_i, wr_i, rd_i, stop_i, dbg_i, osc_run;
   logic mclk, irc, erc, ffc, ffv, dcc, lck, ext_clk;
   logic [2:0] addr_i;
   logic [7:0] wr_data_i, rd_data_o, d;
   logic [3:0] prv;
   int bad_count, n_tests;
   int ec[4];
   wire [3:0] cur = {ffc, erc, irc, mclk};

   always #25 ref_clk_i = ~ref_clk_i;

   csc_ext_osc i_osc (.run_i(osc_run), .half_ns_i(16'd250), .clk_o(ext_clk));

   csc_top i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .pwr_up_i(pwr_up_i), .ce_i(ce_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
      .rd_data_o(rd_data_o), .stop_i(stop_i), .debug_mode_i(dbg_i),
      .ext_ref_clk_i(ext_clk), .main_output_clock_o(mclk),
      .internal_ref_clock_out_o(irc), .external_ref_clock_out_o(erc),
      .fixed_frequency_clock_o(ffc), .fixed_frequency_valid_o(ffv),
      .debug_comm_clock_o(dcc), .loop_locked_o(lck));

   // Rising edges of the four clock outputs, sampled on the system clock.
   always @(posedge ref_clk_i) begin
      for (int i = 0; i < 4; i++) begin
         if (cur[i] === 1'b1 && prv[i] === 1'b0) begin
            ec[i]++;
         end
      end
      prv <= cur;
   end

   // The counter also spends one cycle on its wrap value each half period.
   function automatic int irc_edges(int n, int t, int f);
      return n / (2 * (int'(csc_pkg::IRC_BASE) + t + f + 1));
   endfunction : irc_edges

   function automatic logic [7:0] ffe_exp(int b, int r);
      return {7'h0, r >= b + int'(csc_pkg::FFE_MARGIN)};
   endfunction : ffe_exp

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   // Edge counts start mid-period, so one edge either way is allowed.
   task automatic chk_n(input int got, input int exp);
      n_tests++;
      if (got < exp - 1 || got > exp + 1) begin
         bad_count++;
         $display("Error at %0t: count %h, expected %h", $time, got, exp);
      end
   endtask : chk_n

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      addr_i <= a;
      wr_data_i <= v;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      @(negedge ref_clk_i);
      d = rd_data_o;
   endtask : rd

   task automatic chk_rd(input logic [2:0] a, input logic [7:0] m,
                         input logic [7:0] v);
      rd(a);
      chk(d & m, v);
   endtask : chk_rd

   task automatic wait_stat(input logic [7:0] m, input logic [7:0] v);
      int k;
      k = 0;
      rd(csc_pkg::ADR_STAT);
      while ((d & m) !== v && k < 4000) begin
         rd(csc_pkg::ADR_STAT);
         k++;
      end
      chk(d & m, v);
   endtask : wait_stat

   task automatic meas(input int n);
      @(negedge ref_clk_i);
      ec = '{default: 0};
      repeat (n) @(negedge ref_clk_i);
   endtask : meas

   initial begin
      #(50 * 90000);
      bad_count++;
      give_verdict();
   end

   initial begin
      logic [7:0] t;
      int b;
      int r;
      {sys_rst_i, pwr_up_i, ce_i, osc_run} = 4'hf;
      {wr_i, rd_i, stop_i, dbg_i, addr_i, wr_data_i} = '0;
      bad_count = 0;
      n_tests = 0;
      void'($urandom(32'h36ff));
      @(posedge ref_clk_i);
      pwr_up_i <= 1'b0;
      repeat (7) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      chk_rd(csc_pkg::ADR_CTRL1, 8'hff, csc_pkg::CTRL1_RST);
      chk_rd(csc_pkg::ADR_CTRL2, 8'hff, csc_pkg::CTRL2_RST);
      chk_rd(csc_pkg::ADR_TRIM, 8'hff, csc_pkg::TRIM_PWRUP);
      chk_rd(csc_pkg::ADR_STAT, 8'h1c, 8'h10);
      @(posedge ref_clk_i);
      ce_i <= 1'b0;
      wr(csc_pkg::ADR_CTRL2, 8'hc0);
      ce_i <= 1'b1;
      chk_rd(csc_pkg::ADR_CTRL2, 8'hff, 8'h00);
      for (int a = 4; a < 8; a++) begin
         wr(3'(a), 8'hff);
         chk_rd(3'(a), 8'hff, 8'h00);
      end
      wait_stat(8'h02, 8'h02);
      chk({7'h0, lck}, 8'h01);
      chk({7'h0, ffv}, 8'h01);
      chk({7'h0, dcc}, 8'h01);
      t = 8'h10 + 8'($urandom_range(31));
      wr(csc_pkg::ADR_TRIM, t);
      wr(csc_pkg::ADR_STAT, 8'h01);
      sys_rst_i <= 1'b1;
      @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      chk_rd(csc_pkg::ADR_TRIM, 8'hff, t);
      chk_rd(csc_pkg::ADR_STAT, 8'h01, 8'h01);
      wait_stat(8'h02, 8'h02);
      wr(csc_pkg::ADR_CTRL2, 8'h40);
      wr(csc_pkg::ADR_CTRL1, 8'h46);
      chk_rd(csc_pkg::ADR_STAT, 8'h0c, 8'h00);
      wait_stat(8'h0c, 8'h04);
      meas(2048);
      chk_n(ec[1], irc_edges(2048, t, 1));
      chk_n(ec[0], irc_edges(2048, t, 1) / 2);
      chk_n(ec[3], irc_edges(2048, t, 1));
      wr(csc_pkg::ADR_TRIM, 8'h30);
      wr(csc_pkg::ADR_STAT, 8'h00);
      meas(2048);
      chk_n(ec[1], irc_edges(2048, 8'h30, 0));
      chk_n(ec[0], irc_edges(2048, 8'h30, 0) / 2);
      // The first eight rows sit on either side of the valid threshold.
      for (int i = 0; i < 16; i++) begin
         b = (i < 8) ? i % 4 : int'($urandom_range(3));
         r = (i < 8) ? b + 1 + i / 4 : int'($urandom_range(7));
         wr(csc_pkg::ADR_CTRL2, 8'(b << 6));
         wr(csc_pkg::ADR_CTRL1, {2'b01, 3'(r), 3'b110});
         repeat (3) @(posedge ref_clk_i);
         chk({7'h0, ffv}, ffe_exp(b, r));
      end
      // A slow random divider would make relocking outlast the wait below.
      wr(csc_pkg::ADR_CTRL1, 8'h46);
      wr(csc_pkg::ADR_CTRL2, 8'h08);
      repeat (4) @(posedge ref_clk_i);
      chk({7'h0, dcc}, 8'h00);
      chk({7'h0, lck}, 8'h00);
      dbg_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      chk({7'h0, dcc}, 8'h01);
      dbg_i <= 1'b0;
      wr(csc_pkg::ADR_CTRL2, 8'h00);
      wait_stat(8'h02, 8'h02);
      wr(csc_pkg::ADR_CTRL1, 8'h06);
      wait_stat(8'h0c, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(csc_pkg::ADR_CTRL2, 8'(i << 6));
         meas(256);
         chk_n(ec[0], 128 >> i);
         chk({7'h0, ffv}, 8'h01);
      end
      wr(csc_pkg::ADR_TRIM, 8'h60);
      meas(256);
      chk_n(ec[0], 16);
      osc_run <= 1'b0;
      wr(csc_pkg::ADR_CTRL2, 8'h04);
      wr(csc_pkg::ADR_CTRL1, 8'h86);
      repeat (300) @(posedge ref_clk_i);
      chk_rd(csc_pkg::ADR_STAT, 8'h0e, 8'h02);
      osc_run <= 1'b1;
      wait_stat(8'h0c, 8'h08);
      meas(200);
      chk_n(ec[2], 20);
      chk_n(ec[0], 20);
      wr(csc_pkg::ADR_CTRL1, 8'h87);
      wr(csc_pkg::ADR_CTRL2, 8'h05);
      stop_i <= 1'b1;
      meas(2048);
      chk_n(ec[1], irc_edges(2048, 8'h60, 0));
      chk_n(ec[2], 204);
      chk_n(ec[0], 0);
      wr(csc_pkg::ADR_CTRL1, 8'h86);
      wr(csc_pkg::ADR_CTRL2, 8'h04);
      meas(512);
      chk_n(ec[1], 0);
      chk_n(ec[2], 0);
      stop_i <= 1'b0;
      wr(csc_pkg::ADR_CTRL1, 8'h32);
      chk_rd(csc_pkg::ADR_STAT, 8'h10, 8'h10);
      wait_stat(8'h10, 8'h00);
      wait_stat(8'h0e, 8'h02);
      chk({7'h0, ffv}, 8'h01);
      give_verdict();
   end
endmodule : csc_top_bench
`default_nettype wire
